/* File: logic/serial_adc_pkg.sv */
// constants shared by the serial converter interface
// assumes a 50 MHz system clock sampling all pins
// Notes on behaviour
// - sample serial input on serial clock rise
// - shift result bits out on falling edges
// - serial clock paces conversion; host keeps toggling
// - status goes high when conversion starts
// - status returns low when conversion completes
// - chip select high floats the serial data output and the status output
// - inputs single-ended or differential pair side
// - 8-bit successive approximation, four channels
// - acquisition window open about 375 ns
package serial_adc_pkg;
  localparam int          CLK_MHZ      = 50;
  localparam int          ACQ_NS       = 375;
  localparam int          ACQ_CYCLES   = (ACQ_NS * CLK_MHZ + 999) / 1000;
  localparam int          RESULT_BITS  = 8;
  localparam int          CHAN_BITS    = 2;
  localparam int          CFG_BITS     = 3;
  localparam int          CFG_SINGLE   = 2;
  localparam int          CFG_ODD      = 1;
  localparam int          CFG_SEL      = 0;
  localparam logic [2:0]  CNT_ZERO     = 3'h0;
  localparam logic [2:0]  CNT_MSB      = 3'h7;
  localparam logic [2:0]  CFG_LAST     = 3'h2;

  typedef enum logic [5:0] {
    ST_IDLE    = 6'h01,
    ST_CONFIG  = 6'h02,
    ST_ACQUIRE = 6'h04,
    ST_CONVERT = 6'h08,
    ST_SHIFT   = 6'h10,
    ST_DONE    = 6'h20
  } adc_state_t;
endpackage : serial_adc_pkg

/* File: logic/pin_sync.sv */
// two-stage synchroniser for asynchronous pin inputs
// assumes one destination clock; first stage read only by second
`timescale 1ns/1ps
module pin_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_rst,
  // pin and synced level
  input  wire logic i_pin,
  output logic      o_level
);
  logic meta_r;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      meta_r  <= RESET_VAL;
      o_level <= RESET_VAL;
    end else begin
      meta_r  <= i_pin;
      o_level <= meta_r;
    end
  end
endmodule : pin_sync

/* File: logic/serial_adc_interface.sv */
// serial interface and conversion sequencer of an 8-bit sar converter
// assumes pins arrive asynchronously; comparator output is on i_clock
`timescale 1ns/1ps
module serial_adc_interface
  import serial_adc_pkg::*;
#(
  parameter int RES_BITS = RESULT_BITS
) (
  // clock and reset
  input  wire logic                 i_clock,
  input  wire logic                 i_rst,
  // serial pins from host
  input  wire logic                 i_cs_n,
  input  wire logic                 i_sclk,
  input  wire logic                 i_serial_in,
  // serial pins to host
  output logic                      o_serial_out,
  output logic                      o_serial_out_oe,
  output logic                      o_conversion_active_flag,
  output logic                      o_conversion_active_flag_oe,
  // analog front end control
  output logic                      o_sample,
  output logic                      o_mux_diff,
  output logic [CHAN_BITS-1:0]      o_mux_pos,
  output logic [CHAN_BITS-1:0]      o_mux_neg,
  output logic [RES_BITS-1:0]       o_sar_trial,
  input  wire logic                 i_compare,
  // result for local use
  output logic [RES_BITS-1:0]       o_result,
  output logic                      o_result_valid
);
  logic                  cs_n_s;
  logic                  sclk_s;
  logic                  din_s;
  logic                  sclk_d_r;
  logic                  sclk_rise;
  logic                  sclk_fall;
  adc_state_t            state_r;
  logic [2:0]            cnt_r;
  logic [CFG_BITS-1:0]   cfg_r;
  logic [4:0]            acq_r;
  logic [RES_BITS-1:0]   shift_r;

  pin_sync #(.RESET_VAL(1'b1)) u_sync_cs (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_pin   (i_cs_n),
    .o_level (cs_n_s)
  );
  pin_sync #(.RESET_VAL(1'b0)) u_sync_sclk (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_pin   (i_sclk),
    .o_level (sclk_s)
  );
  pin_sync #(.RESET_VAL(1'b0)) u_sync_din (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_pin   (i_serial_in),
    .o_level (din_s)
  );

  // edge finder on the synced serial clock
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      sclk_d_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk_s;
    end
  end
  assign sclk_rise = sclk_s & ~sclk_d_r;
  assign sclk_fall = ~sclk_s & sclk_d_r;

  // sequencer; deselect aborts any stage
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_r <= ST_IDLE;
      cnt_r   <= CNT_ZERO;
      acq_r   <= '0;
    end else if (cs_n_s) begin
      state_r <= ST_IDLE;
      cnt_r   <= CNT_ZERO;
      acq_r   <= '0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (sclk_rise && din_s) begin
            state_r <= ST_CONFIG;
            cnt_r   <= CNT_ZERO;
          end
        end
        ST_CONFIG: begin
          if (sclk_rise) begin
            if (cnt_r == CFG_LAST) begin
              state_r <= ST_ACQUIRE;
              acq_r   <= '0;
            end
            cnt_r <= cnt_r + 3'h1;
          end
        end
        ST_ACQUIRE: begin
          if (acq_r == 5'(ACQ_CYCLES - 1)) begin
            state_r <= ST_CONVERT;
            cnt_r   <= CNT_MSB;
          end
          acq_r <= acq_r + 5'h1;
        end
        ST_CONVERT: begin
          // one decision per serial clock fall
          if (sclk_fall) begin
            if (cnt_r == CNT_ZERO) begin
              state_r <= ST_SHIFT;
              cnt_r   <= CNT_MSB;
            end else begin
              cnt_r <= cnt_r - 3'h1;
            end
          end
        end
        ST_SHIFT: begin
          if (sclk_fall) begin
            if (cnt_r == CNT_ZERO) begin
              state_r <= ST_DONE;
            end
            cnt_r <= cnt_r - 3'h1;
          end
        end
        ST_DONE: begin
          state_r <= ST_DONE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // configuration bits shifted in msb first
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      cfg_r <= '0;
    end else if (!cs_n_s && state_r == ST_CONFIG && sclk_rise) begin
      cfg_r <= {cfg_r[CFG_BITS-2:0], din_s};
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_mux_diff <= 1'b0;
      o_mux_pos  <= '0;
      o_mux_neg  <= '0;
    end else if (state_r == ST_ACQUIRE) begin
      o_mux_diff <= ~cfg_r[CFG_SINGLE];
      o_mux_pos  <= {cfg_r[CFG_SEL], cfg_r[CFG_ODD]};
      o_mux_neg  <= {cfg_r[CFG_SEL], ~cfg_r[CFG_ODD]};
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_sample <= 1'b0;
    end else begin
      o_sample <= !cs_n_s && state_r == ST_ACQUIRE;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_sar_trial <= '0;
    end else if (state_r == ST_ACQUIRE) begin
      o_sar_trial <= {1'b1, {(RES_BITS-1){1'b0}}};
    end else if (!cs_n_s && state_r == ST_CONVERT && sclk_fall) begin
      o_sar_trial[cnt_r] <= i_compare;
      if (cnt_r != CNT_ZERO) begin
        o_sar_trial[cnt_r - 3'h1] <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_result       <= '0;
      o_result_valid <= 1'b0;
    end else if (!cs_n_s && state_r == ST_CONVERT && sclk_fall && cnt_r == CNT_ZERO) begin
      o_result       <= {o_sar_trial[RES_BITS-1:1], i_compare};
      o_result_valid <= 1'b1;
    end else if (state_r == ST_ACQUIRE) begin
      o_result_valid <= 1'b0;
    end
  end

  // high from window close; low when done
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_conversion_active_flag <= 1'b0;
    end else if (cs_n_s) begin
      o_conversion_active_flag <= 1'b0;
    end else if (state_r == ST_CONVERT && o_sample) begin
      // set on the edge that opens the sample switch, so the two never overlap
      o_conversion_active_flag <= 1'b1;
    end else if (state_r == ST_CONVERT && sclk_fall && cnt_r == CNT_ZERO) begin
      o_conversion_active_flag <= 1'b0;
    end
  end

  // result bits leave on serial clock falls
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      shift_r      <= '0;
      o_serial_out <= 1'b0;
    end else if (cs_n_s || state_r == ST_IDLE) begin
      o_serial_out <= 1'b0;
    end else if (state_r == ST_CONVERT && sclk_fall && cnt_r == CNT_ZERO) begin
      shift_r <= {o_sar_trial[RES_BITS-1:1], i_compare};
    end else if (state_r == ST_SHIFT && sclk_fall) begin
      // msb first, one bit per fall
      o_serial_out <= shift_r[RES_BITS-1];
      shift_r      <= {shift_r[RES_BITS-2:0], 1'b0};
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_serial_out_oe             <= 1'b0;
      o_conversion_active_flag_oe <= 1'b0;
    end else begin
      o_serial_out_oe             <= ~cs_n_s;
      o_conversion_active_flag_oe <= ~cs_n_s;
    end
  end
endmodule : serial_adc_interface

/* File: test/serial_adc_sva.sv */
// assertions on the converter pins and front end outputs
// assumes bind onto serial_adc_interface, one clock domain
`timescale 1ns/1ps
module serial_adc_sva
  import serial_adc_pkg::*;
#(
  parameter int RES_BITS = RESULT_BITS
) (
  // clock, reset, host pins
  input wire logic                i_clock,
  input wire logic                i_rst,
  input wire logic                i_cs_n,
  input wire logic                i_sclk,
  // observed outputs
  input wire logic                o_serial_out,
  input wire logic                o_serial_out_oe,
  input wire logic                o_conversion_active_flag,
  input wire logic                o_conversion_active_flag_oe,
  input wire logic                o_sample,
  input wire logic [RES_BITS-1:0] o_sar_trial,
  input wire logic                o_result_valid
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  logic [4:0] scnt_r;
  always_ff @(posedge i_clock) begin
    if (i_rst) scnt_r <= 5'h00;
    else scnt_r <= o_sample ? scnt_r + 5'h01 : 5'h00;
  end
  sequence s_acq_end;
    $fell(o_sample);
  endsequence
  a_out_float: assert property (i_cs_n [*5] |-> !o_serial_out_oe)
    else $error("output enabled while deselected");
  a_flag_float: assert property (!o_conversion_active_flag_oe &&
    !$past(o_conversion_active_flag_oe) |-> !o_conversion_active_flag)
    else $error("flag high while floating");
  a_acq_len: assert property (s_acq_end |-> int'(scnt_r) == ACQ_CYCLES)
    else $error("acquisition window length wrong");
  a_flag_start: assert property (s_acq_end |-> ##[0:2] o_conversion_active_flag)
    else $error("flag did not rise after window");
  a_no_overlap: assert property (o_conversion_active_flag |-> !o_sample)
    else $error("sampling during conversion");
  a_trial_msb: assert property ($rose(o_conversion_active_flag)
    |-> ##[0:1] o_sar_trial == 8'h80)
    else $error("first trial not midscale");
  a_valid_end: assert property ($fell(o_conversion_active_flag) &&
    o_conversion_active_flag_oe |-> ##[0:1] o_result_valid)
    else $error("no result at conversion end");
  a_out_quiet: assert property (o_conversion_active_flag |-> !o_serial_out)
    else $error("data out during conversion");
  a_out_fall: assert property ($changed(o_serial_out) && o_serial_out_oe
    |-> !$past(i_sclk, 2))
    else $error("data out moved off a falling edge");
endmodule : serial_adc_sva
bind serial_adc_interface serial_adc_sva #(.RES_BITS(RES_BITS)) chk (
  .i_clock                     (i_clock),
  .i_rst                       (i_rst),
  .i_cs_n                      (i_cs_n),
  .i_sclk                      (i_sclk),
  .o_serial_out                (o_serial_out),
  .o_serial_out_oe             (o_serial_out_oe),
  .o_conversion_active_flag    (o_conversion_active_flag),
  .o_conversion_active_flag_oe (o_conversion_active_flag_oe),
  .o_sample                    (o_sample),
  .o_sar_trial                 (o_sar_trial),
  .o_result_valid              (o_result_valid)
);

/* File: test/host_model.sv */
// host side model driving select, serial clock and serial input
// assumes a 160 ns serial clock that stands low outside frames
`timescale 1ns/1ps
module host_model (
  // pins to device
  output logic      o_cs_n,
  output logic      o_sclk,
  output logic      o_din,
  // pin from device
  input  wire logic i_dout
);
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_din = 1'b0;
  end
  task automatic frame(input logic [2:0] c, input logic ab, output logic [7:0] r);
    logic [3:0] cmd;
    cmd = {1'b1, c};
    r = 8'h00;
    o_cs_n = 1'b0;
    #160;
    for (int i = 3; i >= 0; i--) begin
      o_din = cmd[i];
      #80 o_sclk = 1'b1;
      #80 o_sclk = 1'b0;
    end
    // released line shows inverse
    o_din = ~o_din;
    #480;
    for (int k = 0; k < 17; k++) begin
      #80 o_sclk = 1'b1;
      if (k > 8) r = {r[6:0], i_dout};
      if (k == 16 || (ab && k == 3)) break;
      #80 o_sclk = 1'b0;
    end
    #80 o_sclk = 1'b0;
    if (ab) deselect();
  endtask : frame
  task automatic deselect();
    #80 o_cs_n = 1'b1;
    #320;
  endtask : deselect
endmodule : host_model

/* File: test/serial_adc_interface_bench.sv */
// self-checking bench for the serial converter interface
// assumes host_model on the pins and an ideal comparator
`timescale 1ns/1ps
module serial_adc_interface_bench;
  import serial_adc_pkg::*;
  logic i_clock = 1'b0, i_rst = 1'b1, cmp, dout, dout_oe, flag, flag_oe;
  logic cs_n, sclk, din, smp, diff, rv, dout_pin;
  logic [1:0] pos, neg;
  logic [7:0] trial, res, vin = 8'h00;
  int n_mismatch = 0, n_compared = 0;
  // ideal comparator: input at or above trial
  assign cmp = (vin >= trial) === 1'b1;
  initial forever #10 i_clock = ~i_clock;
  serial_adc_interface uut (.i_clock(i_clock), .i_rst(i_rst), .i_cs_n(cs_n), .i_sclk(sclk),
    .i_serial_in(din), .o_serial_out(dout), .o_serial_out_oe(dout_oe),
    .o_conversion_active_flag(flag), .o_conversion_active_flag_oe(flag_oe),
    .o_sample(smp), .o_mux_diff(diff), .o_mux_pos(pos), .o_mux_neg(neg),
    .o_sar_trial(trial), .i_compare(cmp), .o_result(res), .o_result_valid(rv));
  // floating data pin shows the inverse, so a missing enable is caught
  assign dout_pin = dout_oe ? dout : ~dout;
  host_model host (.o_cs_n(cs_n), .o_sclk(sclk), .o_din(din), .i_dout(dout_pin));
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (e !== g) begin
      n_mismatch++;
      $display("unexpected t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  task automatic t_convert(input logic [2:0] c, input logic [7:0] v);
    logic [7:0] got;
    @(posedge i_clock);
    #1 vin = v;
    host.frame(c, 1'b0, got);
    chk(v, got);
    chk(v, res);
    chk(8'h01, {7'h0, rv});
    chk(8'h02, {6'h0, flag_oe, flag});
    chk({5'h0, ~c[2], c[0], c[1]}, {5'h0, diff, pos});
    if (!c[2]) chk({6'h0, c[0], ~c[1]}, {6'h0, neg});
    host.deselect();
    chk(8'h00, {6'h0, dout_oe, flag_oe});
  endtask : t_convert
  task automatic t_abort();
    logic [7:0] got;
    @(posedge i_clock);
    #1 vin = 8'h33;
    host.frame(3'b100, 1'b1, got);
    chk(8'h00, {4'h0, dout_oe, flag_oe, flag, dout});
  endtask : t_abort
  task automatic tally_and_finish();
    if (n_mismatch == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (4) @(posedge i_clock);
    #1 i_rst = 1'b0;
    repeat (4) @(posedge i_clock);
    t_convert(3'b100, 8'h00);
    t_convert(3'b111, 8'hff);
    t_abort();
    t_convert(3'b001, 8'ha5);
    t_convert(3'b010, 8'h5a);
    tally_and_finish();
  end
  // five frames take about 20 us
  initial begin
    #200000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule : serial_adc_interface_bench
